// File: hdl/ifcd_consts.svh
// Purpose: Constants of the instruction format and cycle decoder
// Assumes: 24-bit program words, 8-bit opcode in the top byte
// Notes:   Field macros are bit slices of the decoded word
`ifndef IFCD_CONSTS_SVH
`define IFCD_CONSTS_SVH
// ----------------------------------------
// Word layout
// ----------------------------------------
`define IFCD_WORD_W 24
`define IFCD_F_OPC 23:16
`define IFCD_F_BASE 15:12
`define IFCD_F_DMODE 11:10
`define IFCD_F_DEST 9:6
`define IFCD_F_SMODE 5:4
`define IFCD_F_SRC 3:0
`define IFCD_F_FILE 12:0
`define IFCD_B_FDEST 13
`define IFCD_F_BFILE 11:0
`define IFCD_F_BPOS 15:12
`define IFCD_F_LLIT 15:4
`define IFCD_F_LFLIT 15:8
`define IFCD_F_LFADR 7:0
`define IFCD_F_ALIT 11:7
`define IFCD_B_SAME 6
`define IFCD_B_ACC 15
`define IFCD_F_PAIR 14:12
`define IFCD_F_XPF 11:8
`define IFCD_F_XDST 7:6
`define IFCD_F_AWB 5:4
`define IFCD_B_SHREG 14
`define IFCD_F_SHREG 13:10
`define IFCD_F_SHLIT 13:8
`define IFCD_F_TMODE 15:14
`define IFCD_F_PADDR 15:0
`define IFCD_F_TADDR 6:0
`define IFCD_B_FILETGT 3
`define IFCD_B_INDIR 2
// ----------------------------------------
// Opcode map
// ----------------------------------------
`define IFCD_OP_NOP 8'h00
`define IFCD_OP_CALL2 8'h02
`define IFCD_OP_GOTO2 8'h04
`define IFCD_OP_LOOP2 8'h08
`define IFCD_OP_RETURN 8'hFE
`define IFCD_OP_INTERRUPT_RETURN 8'hFF
`define IFCD_JMP_TOP 6'h38
`define IFCD_TBL_TOP 6'h39
`define IFCD_CBR_TOP 5'h1D
`define IFCD_SKP_TOP 5'h1E
`define IFCD_NIB_ZERO 4'h0
`define IFCD_NIB_LMOV 4'h2
`define IFCD_NIB_LARI 4'h3
`define IFCD_WOP_TOP 2'h1
`define IFCD_NIB_DMOV 4'h9
`define IFCD_NIB_BIT 4'hA
`define IFCD_NIB_FILE 4'hB
`define IFCD_NIB_MAC 4'hC
`define IFCD_NIB_DSP 4'hD
`define IFCD_NIB_F 4'hF
// ----------------------------------------
// Operand codes and cycle counts
// ----------------------------------------
`define IFCD_REG_W0 4'h0
`define IFCD_REG_W4 4'h4
`define IFCD_REG_W5 4'h5
`define IFCD_REG_W6 4'h6
`define IFCD_REG_W7 4'h7
`define IFCD_REG_W8 4'h8
`define IFCD_REG_W9 4'h9
`define IFCD_PAIR_MAX 3'h5
`define IFCD_XPF_SPECIAL 3'h4
`define IFCD_AWB_NONE 2'h0
`define IFCD_AWB_W13 2'h1
`define IFCD_AWB_W13_PI2 2'h2
`define IFCD_CYC1 2'h1
`define IFCD_CYC2 2'h2
`define IFCD_CYC3 2'h3
`endif

// File: hdl/ifcd_pkg.sv
// Purpose: Types of the instruction format and cycle decoder
// Assumes: Nothing
// Notes:   Constants live in ifcd_consts.svh
package ifcd_pkg;
   typedef enum logic [2:0] {
      CLS_WORD, CLS_BIT, CLS_LIT, CLS_DSP, CLS_CTRL
   } ifcd_class_type;
   typedef enum logic [1:0] {
      ST_IDLE, ST_TAIL, ST_SKIP, ST_DROP
   } ifcd_state_type;
endpackage : ifcd_pkg

// File: hdl/ifcd_decoder.sv
// Purpose: Decode program words into class, operands and cycle count
// Assumes: Fetch path and datapath share core_clk_i
// Notes:   Two-word and skipped words are swallowed, not issued
`timescale 1ns/1ns
`include "ifcd_consts.svh"

module ifcd_decoder
   import ifcd_pkg::*;
(
   input wire logic core_clk_i, // 10 MHz instruction clock
   input wire logic reset_i, // Synchronous, active high
   input wire logic [`IFCD_WORD_W-1:0] word_i, // Fetched word
   input wire logic word_valid_i, // Word present this cycle
   input wire logic cond_true_i, // Condition or skip test true
   output ifcd_class_type class_o, // Instruction class
   output logic dec_valid_o, // One-cycle issue pulse
   output logic [7:0] opcode_o, // Opcode byte
   output logic illegal_o, // Unassigned opcode or pair
   output logic two_word_o, // Issued from two words
   output logic tail_nonzero_o, // Tail top byte not zero
   output logic [1:0] cycles_o, // Instruction cycles
   output logic [3:0] base_operand_reg_o, // Base register
   output logic [3:0] source_operand_reg_o, // Source register
   output logic [1:0] src_mode_o, // Source address mode
   output logic [3:0] dest_operand_reg_o, // Destination register
   output logic [1:0] dest_mode_o, // Destination address mode
   output logic dest_valid_o, // Destination decoded
   output logic [12:0] file_addr_o, // File register address
   output logic file_target_o, // Target is a file register
   output logic file_default_dest_o, // Result goes to W0
   output logic [3:0] bit_pos_o, // Bit position literal
   output logic bit_pos_indirect_o, // Bit position from base
   output logic [15:0] literal_o, // Literal operand
   output logic acc_sel_o, // 0 selects A, 1 selects B
   output logic [3:0] mul_a_o, // Multiplicand register
   output logic [3:0] mul_b_o, // Multiplier register
   output logic xpf_en_o, // X prefetch present
   output logic [3:0] xpf_reg_o, // X prefetch address reg
   output logic [3:0] xpf_step_o, // Signed post-modify
   output logic xpf_w12_ofs_o, // Offset by W12
   output logic [3:0] xpf_dest_o, // Prefetch destination
   output logic [1:0] acc_writeback_target_o, // Write-back form
   output logic shift_by_reg_o, // Shift amount from register
   output logic [3:0] shift_count_reg_o, // Shift amount register
   output logic [5:0] shift_lit_o, // Shift amount literal
   output logic [22:0] prog_addr_o, // Program memory address
   output logic [1:0] table_mode_o // Table access mode
);

   // ----------------------------------------
   // Word selection and opcode groups
   // ----------------------------------------
   ifcd_state_type st_r;
   ifcd_state_type st_nxt;
   logic [`IFCD_WORD_W-1:0] first_r;
   logic issue;
   logic [1:0] cyc;

   // Held leading word once a tail or skip is pending
   wire [`IFCD_WORD_W-1:0] w = (st_r == ST_IDLE) ? word_i : first_r;
   wire [7:0] op = w[`IFCD_F_OPC];
   wire [3:0] nib = op[7:4];
   wire [7:0] nx_op = word_i[`IFCD_F_OPC];
   wire nx_two = (nx_op == `IFCD_OP_CALL2) | (nx_op == `IFCD_OP_GOTO2)
      | (nx_op == `IFCD_OP_LOOP2);

   wire in_wop = nib[3:2] == `IFCD_WOP_TOP;
   wire in_dmov = nib == `IFCD_NIB_DMOV;
   wire in_file = nib == `IFCD_NIB_FILE;
   wire in_bit = nib == `IFCD_NIB_BIT;
   wire in_lmov = nib == `IFCD_NIB_LMOV;
   wire in_lari = nib == `IFCD_NIB_LARI;
   wire in_mac = nib == `IFCD_NIB_MAC;
   wire in_dsp = nib == `IFCD_NIB_DSP;
   wire in_jmp = op[7:2] == `IFCD_JMP_TOP;
   wire in_tbl = op[7:2] == `IFCD_TBL_TOP;
   wire in_cbr = op[7:3] == `IFCD_CBR_TOP;
   wire in_skp = op[7:3] == `IFCD_SKP_TOP;
   wire in_ret = (op == `IFCD_OP_RETURN)
      | (op == `IFCD_OP_INTERRUPT_RETURN);
   wire in_zero = (op == `IFCD_OP_NOP) | (op == `IFCD_OP_CALL2)
      | (op == `IFCD_OP_GOTO2) | (op == `IFCD_OP_LOOP2);

   wire ifcd_class_type cls = (in_wop | in_dmov | in_file) ? CLS_WORD
      : in_bit ? CLS_BIT
      : (in_lmov | in_lari) ? CLS_LIT
      : (in_mac | in_dsp) ? CLS_DSP
      : CLS_CTRL;

   wire [2:0] pair = w[`IFCD_F_PAIR];
   wire bad_f = (nib == `IFCD_NIB_F) & op[3] & ~in_ret;
   wire bad_zero = (nib == `IFCD_NIB_ZERO) & ~in_zero;
   wire illegal = bad_f | bad_zero | (in_mac & (pair > `IFCD_PAIR_MAX))
      | (~in_wop & ~in_dmov & ~in_file & ~in_bit & ~in_lmov & ~in_lari
      & ~in_mac & ~in_dsp & (nib[3:1] != 3'h7) & (nib != 4'h0));

   // ----------------------------------------
   // Operand fields
   // ----------------------------------------
   wire lmov_file = in_lmov & op[`IFCD_B_FILETGT];
   wire bit_file = in_bit & op[`IFCD_B_FILETGT];
   wire same_dst = in_lari & w[`IFCD_B_SAME];
   wire [3:0] dest = in_lmov ? w[`IFCD_F_SRC]
      : same_dst ? w[`IFCD_F_BASE]
      : in_lari ? w[`IFCD_F_SRC]
      : w[`IFCD_F_DEST];
   wire dest_v = in_wop | in_dmov | (in_lmov & ~lmov_file)
      | (in_lari & ~same_dst);
   wire [12:0] faddr = in_file ? w[`IFCD_F_FILE]
      : bit_file ? {1'b0, w[`IFCD_F_BFILE]}
      : {5'h00, w[`IFCD_F_LFADR]};
   wire [15:0] lit = lmov_file ? {8'h00, w[`IFCD_F_LFLIT]}
      : in_lmov ? {4'h0, w[`IFCD_F_LLIT]}
      : in_lari ? {11'h000, w[`IFCD_F_ALIT]}
      : w[`IFCD_F_PADDR];

   // Pair code 0..5 walks the six distinct pairs in order
   wire [3:0] mul_a = (pair < 3'h3) ? `IFCD_REG_W4
      : (pair < 3'h5) ? `IFCD_REG_W5 : `IFCD_REG_W6;
   wire [3:0] mul_b = (pair == 3'h0) ? `IFCD_REG_W5
      : (pair == 3'h1 || pair == 3'h3) ? `IFCD_REG_W6
      : `IFCD_REG_W7;

   // X prefetch: bit 3 picks W9, low bits pick the post-modify
   wire [3:0] xf = w[`IFCD_F_XPF];
   wire xf_sp = xf[2:0] == `IFCD_XPF_SPECIAL;
   wire [3:0] mag = {1'b0, xf[1:0], 1'b0};
   wire [3:0] xstep = xf[2] ? (4'h0 - mag) : mag;
   wire [1:0] acc_writeback_target = (w[`IFCD_F_AWB] == 2'h3) ? `IFCD_AWB_NONE
      : w[`IFCD_F_AWB];

   // ----------------------------------------
   // Cycle count of a one-word issue
   // ----------------------------------------
   wire [1:0] cyc_one = in_ret ? `IFCD_CYC3
      : (in_jmp | in_tbl | in_dmov) ? `IFCD_CYC2
      : (in_cbr & cond_true_i) ? `IFCD_CYC2
      : `IFCD_CYC1;

   // ----------------------------------------
   // Sequencer for tails and skips
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      issue = 1'b0;
      cyc = cyc_one;
      case (st_r)
         ST_IDLE: begin
            if (word_valid_i) begin
               if (nx_two) begin
                  st_nxt = ST_TAIL;
               end else if (in_skp & cond_true_i) begin
                  st_nxt = ST_SKIP;
               end else begin
                  issue = 1'b1;
               end
            end
         end
         ST_TAIL: begin
            if (word_valid_i) begin
               issue = 1'b1;
               cyc = `IFCD_CYC2;
               st_nxt = ST_IDLE;
            end
         end
         ST_SKIP: begin
            if (word_valid_i) begin
               issue = 1'b1;
               cyc = nx_two ? `IFCD_CYC3 : `IFCD_CYC2;
               st_nxt = nx_two ? ST_DROP : ST_IDLE;
            end
         end
         ST_DROP: begin
            if (word_valid_i) begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st_r <= ST_IDLE;
         first_r <= 24'h000000;
      end else begin
         st_r <= st_nxt;
         if (st_r == ST_IDLE && word_valid_i) begin
            first_r <= word_i;
         end
      end
   end

   // ----------------------------------------
   // Issue registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         dec_valid_o <= 1'b0;
         class_o <= CLS_CTRL;
         {opcode_o, illegal_o, two_word_o, tail_nonzero_o} <= 11'h000;
         cycles_o <= `IFCD_CYC1;
         {base_operand_reg_o, source_operand_reg_o} <= 8'h00;
         {src_mode_o, dest_mode_o, dest_operand_reg_o} <= 8'h00;
         {dest_valid_o, file_target_o, file_default_dest_o} <= 3'h0;
         {file_addr_o, bit_pos_o, bit_pos_indirect_o} <= 18'h00000;
         {literal_o, acc_sel_o, mul_a_o, mul_b_o} <= 25'h0000000;
         {xpf_en_o, xpf_reg_o, xpf_step_o, xpf_w12_ofs_o} <= 10'h000;
         {xpf_dest_o, acc_writeback_target_o} <= 6'h00;
         {shift_by_reg_o, shift_count_reg_o, shift_lit_o} <= 11'h000;
         {prog_addr_o, table_mode_o} <= 25'h0000000;
      end else begin
         dec_valid_o <= issue;
         if (issue) begin
            class_o <= cls;
            opcode_o <= op;
            illegal_o <= illegal;
            cycles_o <= cyc;
            two_word_o <= st_r == ST_TAIL;
            tail_nonzero_o <= (st_r == ST_TAIL)
               && (nx_op != 8'h00);
            base_operand_reg_o <= w[`IFCD_F_BASE];
            source_operand_reg_o <= w[`IFCD_F_SRC];
            src_mode_o <= w[`IFCD_F_SMODE];
            dest_operand_reg_o <= dest;
            dest_mode_o <= w[`IFCD_F_DMODE];
            dest_valid_o <= dest_v;
            file_addr_o <= faddr;
            file_target_o <= in_file | bit_file | lmov_file;
            file_default_dest_o <= in_file & ~w[`IFCD_B_FDEST];
            bit_pos_o <= w[`IFCD_F_BPOS];
            bit_pos_indirect_o <= in_bit & op[`IFCD_B_INDIR];
            literal_o <= lit;
            acc_sel_o <= w[`IFCD_B_ACC];
            mul_a_o <= mul_a;
            mul_b_o <= mul_b;
            xpf_en_o <= in_mac & ~(xf_sp & ~xf[3]);
            xpf_reg_o <= xf[3] ? `IFCD_REG_W9 : `IFCD_REG_W8;
            xpf_step_o <= xstep;
            xpf_w12_ofs_o <= in_mac & xf_sp & xf[3];
            xpf_dest_o <= {2'h1, w[`IFCD_F_XDST]};
            acc_writeback_target_o <= in_mac ? acc_writeback_target : `IFCD_AWB_NONE;
            shift_by_reg_o <= in_dsp & w[`IFCD_B_SHREG];
            shift_count_reg_o <= w[`IFCD_F_SHREG];
            shift_lit_o <= w[`IFCD_F_SHLIT];
            prog_addr_o <= (st_r == ST_TAIL)
               ? {word_i[`IFCD_F_TADDR], first_r[`IFCD_F_PADDR]}
               : {7'h00, w[`IFCD_F_PADDR]};
            table_mode_o <= in_tbl ? w[`IFCD_F_TMODE] : 2'h0;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_lead;
      st_r == ST_IDLE && word_valid_i && nx_two;
   endsequence
   sequence s_tail;
      st_r == ST_TAIL && word_valid_i;
   endsequence

   a_tail_swallow: assert property (s_lead |=> !dec_valid_o)
      else $error("lead word of a pair was issued");
   a_pair_issue: assert property (
      s_lead ##1 s_tail |=>
      dec_valid_o && two_word_o && cycles_o == `IFCD_CYC2)
      else $error("two-word issue wrong");
   a_tail_zero: assert property (
      s_tail |=>
      tail_nonzero_o == ($past(word_i[`IFCD_F_OPC]) != 8'h00))
      else $error("tail top byte check wrong");
   a_opcode_field: assert property (
      st_r == ST_IDLE && word_valid_i
      && !nx_two && !(in_skp && cond_true_i) |=>
      dec_valid_o && opcode_o == $past(word_i[`IFCD_F_OPC]))
      else $error("opcode not taken from top byte");
   a_nop_alone: assert property (
      dec_valid_o && opcode_o == 8'h00 |->
      class_o == CLS_CTRL && cycles_o == `IFCD_CYC1)
      else $error("lone tail not a no-op");
   a_skip_three: assert property (
      st_r == ST_SKIP && word_valid_i && nx_two |=>
      dec_valid_o && cycles_o == `IFCD_CYC3 ##1 !dec_valid_o)
      else $error("skip over pair wrong");
   a_cond_cycles: assert property (
      st_r == ST_IDLE && word_valid_i && in_cbr |=>
      cycles_o == ($past(cond_true_i) ? `IFCD_CYC2 : `IFCD_CYC1))
      else $error("conditional cycles wrong");
   a_mul_pair: assert property (
      dec_valid_o && !illegal_o && opcode_o[7:4] == `IFCD_NIB_MAC |->
      mul_a_o < mul_b_o && mul_a_o >= `IFCD_REG_W4
      && mul_b_o <= `IFCD_REG_W7)
      else $error("multiply pair out of range");
   a_xpf_regs: assert property (
      xpf_en_o |-> opcode_o[7:4] == `IFCD_NIB_MAC
      && (xpf_reg_o == `IFCD_REG_W8 || xpf_reg_o == `IFCD_REG_W9)
      && !(xpf_w12_ofs_o && xpf_reg_o == `IFCD_REG_W8))
      else $error("prefetch register wrong");
   a_awb_form: assert property (
      dec_valid_o |-> acc_writeback_target_o != 2'h3
      && (opcode_o[7:4] == `IFCD_NIB_MAC
      || acc_writeback_target_o == `IFCD_AWB_NONE))
      else $error("write-back form wrong");
   a_file_dest: assert property (
      file_default_dest_o |-> class_o == CLS_WORD && file_target_o)
      else $error("W0 destination outside file ops");

endmodule : ifcd_decoder

// File: tb/ifcd_fetch_model.sv
// Purpose: Fetch path model feeding program words to the decoder
// Assumes: Words change at the falling clock edge
// Notes:   Each idle cycle inverts the bus word, so every second one shows the last word again
`timescale 1ns/1ns
module ifcd_fetch_model (
   input wire logic core_clk_i, // Core clock
   output logic [23:0] word_o, // Program word
   output logic word_valid_o, // Word present
   output logic cond_true_o // Condition for this word
);
   initial begin
      word_o = 24'h000000;
      word_valid_o = 1'b0;
      cond_true_o = 1'b0;
   end
   // A gap above zero models a slow fetch
   task automatic send(input logic [23:0] w, input logic c, input int gap);
      idle(gap);
      @(negedge core_clk_i);
      word_o = w;
      word_valid_o = 1'b1;
      cond_true_o = c;
   endtask : send
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge core_clk_i);
         word_o = ~word_o;
         word_valid_o = 1'b0;
         cond_true_o = ~cond_true_o;
      end
   endtask : idle
endmodule : ifcd_fetch_model

// File: tb/tb_top.sv
// Purpose: Self-checking bench of the instruction decoder
// Assumes: Fetch model drives words at the falling edge
// Notes:   Issue pulses are counted at every falling edge
`timescale 1ns/1ns
`include "ifcd_consts.svh"
module tb_top
   import ifcd_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [23:0] word_i;
   logic word_valid_i, cond_true_i, dec_valid_o, illegal_o, two_word_o;
   logic tail_nonzero_o, dest_valid_o, file_target_o, file_default_dest_o;
   logic bit_pos_indirect_o, acc_sel_o, xpf_en_o, xpf_w12_ofs_o;
   logic shift_by_reg_o;
   ifcd_class_type class_o;
   logic [1:0] cycles_o, src_mode_o, dest_mode_o, acc_writeback_target_o;
   logic [1:0] table_mode_o;
   logic [3:0] base_operand_reg_o, source_operand_reg_o, dest_operand_reg_o;
   logic [3:0] bit_pos_o, mul_a_o, mul_b_o, xpf_reg_o, xpf_step_o;
   logic [3:0] xpf_dest_o, shift_count_reg_o;
   logic [5:0] shift_lit_o;
   logic [7:0] opcode_o;
   logic [12:0] file_addr_o;
   logic [15:0] literal_o;
   logic [22:0] prog_addr_o;
   int error_cnt = 0;
   int total_checks = 0;
   int pulse_cnt = 0;
   int mark = 0;
   always #50 core_clk_i = ~core_clk_i;
   ifcd_decoder i_dut (
      .core_clk_i, .reset_i, .word_i, .word_valid_i, .cond_true_i, .class_o,
      .dec_valid_o, .opcode_o, .illegal_o, .two_word_o, .tail_nonzero_o,
      .cycles_o, .base_operand_reg_o, .source_operand_reg_o, .src_mode_o,
      .dest_operand_reg_o, .dest_mode_o, .dest_valid_o, .file_addr_o,
      .file_target_o, .file_default_dest_o, .bit_pos_o, .bit_pos_indirect_o,
      .literal_o, .acc_sel_o, .mul_a_o, .mul_b_o, .xpf_en_o, .xpf_reg_o,
      .xpf_step_o, .xpf_w12_ofs_o, .xpf_dest_o, .acc_writeback_target_o,
      .shift_by_reg_o, .shift_count_reg_o, .shift_lit_o, .prog_addr_o,
      .table_mode_o
   );
   ifcd_fetch_model i_fetch (
      .core_clk_i, .word_o(word_i), .word_valid_o(word_valid_i),
      .cond_true_o(cond_true_i)
   );
   always @(negedge core_clk_i) begin
      if (dec_valid_o === 1'b1) begin
         pulse_cnt = pulse_cnt + 1;
      end
   end
   // -----
   // Checking and sequencing
   // -----
   task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                      input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t ns: %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk
   task automatic chk_cls(input ifcd_class_type got, ifcd_class_type exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t ns: class got %0d exp %0d", $time, got, exp);
      end
   endtask : chk_cls
   task automatic results();
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results
   // Closes a burst of words that must yield n issues
   task automatic fin(input int n);
      int i;
      i_fetch.idle(1);
      for (i = 0; i < 20 && pulse_cnt < mark + n; i++) begin
         @(negedge core_clk_i);
         #1;
      end
      if (pulse_cnt < mark + n) begin
         error_cnt++;
         $display("ERROR %0t ns: issue timed out", $time);
         results();
      end
      repeat (3) @(negedge core_clk_i);
      #1;
      chk(pulse_cnt - mark, n, "issues");
      mark = pulse_cnt;
   endtask : fin
   task automatic one(input logic [23:0] w, input logic c);
      i_fetch.send(w, c, 0);
      fin(1);
   endtask : one
   task automatic do_reset(input int n);
      @(negedge core_clk_i);
      reset_i = 1'b1;
      repeat (n) @(negedge core_clk_i);
      reset_i = 1'b0;
      #1;
      chk(dec_valid_o, 0, "rst valid");
      chk_cls(class_o, CLS_CTRL);
      chk(cycles_o, 1, "rst cycles");
      mark = pulse_cnt;
   endtask : do_reset
   // -----
   // Scenarios
   // -----
   task automatic t_word();
      logic [23:0] w;
      w = 24'h7A9DE3;
      i_fetch.send(24'h401234, 1'b0, 0);
      i_fetch.send(w, 1'b1, 0);
      fin(2);
      chk(opcode_o, w[23:16], "opcode");
      chk_cls(class_o, CLS_WORD);
      chk(base_operand_reg_o, w[15:12], "base");
      chk(source_operand_reg_o, w[3:0], "src");
      chk(src_mode_o, w[5:4], "src mode");
      chk(dest_operand_reg_o, w[9:6], "dest");
      chk(dest_mode_o, w[11:10], "dest mode");
      chk(cycles_o, 1, "cycles");
   endtask : t_word
   task automatic t_file_bit();
      logic [23:0] w;
      for (int k = 0; k < 2; k++) begin
         w = {8'hB3, 2'b00, 1'(k), 13'h1A5C};
         one(w, 1'b0);
         chk_cls(class_o, CLS_WORD);
         chk(file_addr_o, w[12:0], "file");
         chk(file_default_dest_o, !w[13], "to W0");
         w = {4'hA, 1'(k), 1'(k), 2'b01, 16'h7E3C};
         one(w, 1'b0);
         chk_cls(class_o, CLS_BIT);
         chk(bit_pos_o, w[15:12], "bit pos");
         chk(bit_pos_indirect_o, w[18], "indirect");
         chk(file_target_o, w[19], "bit tgt");
         if (k == 1) chk(file_addr_o, w[11:0], "bit file");
      end
   endtask : t_file_bit
   task automatic t_lit();
      one(24'h28A53C, 1'b0);
      chk_cls(class_o, CLS_LIT);
      chk(literal_o, 16'h00A5, "lit8");
      chk(file_addr_o, 13'h003C, "lit file");
      one(24'h22ABC7, 1'b0);
      chk(literal_o, 16'h0ABC, "lit12");
      chk(dest_operand_reg_o, 4'h7, "lit dest");
      one(24'h315FC0, 1'b0);
      chk(base_operand_reg_o, 4'h5, "ar base");
      chk(literal_o, 16'h001F, "ar lit");
      chk(dest_valid_o, 0, "same dest");
      one(24'h315F8A, 1'b0);
      chk(dest_valid_o, 1, "new dest");
      chk(dest_operand_reg_o, 4'hA, "ar dest");
   endtask : t_lit
   task automatic t_mac();
      logic [3:0] pa [6] = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6};
      logic [3:0] pb [6] = '{4'h5, 4'h6, 4'h7, 4'h6, 4'h7, 4'h7};
      logic [3:0] st [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h0, 4'hE, 4'hC, 4'hA};
      logic [23:0] w;
      logic [2:0] p;
      logic [3:0] x;
      logic [1:0] wb;
      for (int i = 0; i < 16; i++) begin
         p = 3'(i % 7);
         x = 4'(i);
         w = {8'hC5, 1'(i), p, x, 2'(i), 2'(i >> 1), 4'h3};
         one(w, 1'b0);
         chk_cls(class_o, CLS_DSP);
         chk(acc_sel_o, w[15], "acc");
         chk(illegal_o, p == 3'h6, "pair ok");
         if (p != 3'h6) begin
            chk(mul_a_o, pa[p], "mul a");
            chk(mul_b_o, pb[p], "mul b");
            chk(xpf_en_o, x != 4'h4, "xpf en");
            chk(xpf_reg_o, x[3] ? 4'h9 : 4'h8, "xpf reg");
            chk(xpf_w12_ofs_o, x == 4'hC, "w12");
            if (x[2:0] != 3'h4) chk(xpf_step_o, st[x[2:0]], "step");
            chk(xpf_dest_o, 4'h4 + w[7:6], "xpf dst");
            wb = (w[5:4] == 2'h3) ? 2'h0 : w[5:4];
            chk(acc_writeback_target_o, wb, "wb");
         end
      end
   endtask : t_mac
   task automatic t_dsp();
      logic [23:0] w;
      w = 24'hD2DB7F;
      one(w, 1'b0);
      chk_cls(class_o, CLS_DSP);
      chk(acc_sel_o, 1, "acc");
      chk(shift_by_reg_o, 1, "by reg");
      chk(shift_count_reg_o, w[13:10], "sh reg");
      w = 24'hD02A00;
      one(w, 1'b0);
      chk(acc_sel_o, 0, "acc");
      chk(shift_by_reg_o, 0, "by lit");
      chk(shift_lit_o, w[13:8], "sh lit");
   endtask : t_dsp
   task automatic t_ctrl();
      logic [7:0] op [9] = '{8'hE1, 8'hE5, 8'hEA, 8'hEA, 8'hFE, 8'hFF,
                             8'h92, 8'h10, 8'h84};
      logic cd [9] = '{1, 0, 1, 0, 0, 1, 0, 0, 0};
      logic [1:0] cy [7] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h3, 2'h3, 2'h2};
      for (int i = 0; i < 9; i++) begin
         one({op[i], 16'h8ADE}, cd[i]);
         chk(illegal_o, i > 6, "illegal");
         if (i < 7) chk(cycles_o, cy[i], "cycles");
         if (i < 6) chk_cls(class_o, CLS_CTRL);
         if (i == 1) chk(table_mode_o, 2'h2, "tbl mode");
      end
   endtask : t_ctrl
   task automatic t_pair();
      logic [7:0] op [3] = '{`IFCD_OP_CALL2, `IFCD_OP_GOTO2, `IFCD_OP_LOOP2};
      logic [23:0] ld, tl;
      for (int i = 0; i < 4; i++) begin
         ld = {op[i % 3], 16'h8421};
         tl = {i == 3 ? 8'h5A : 8'h00, 9'h000, 7'(7'h35 + i)};
         i_fetch.send(ld, 1'b0, 0);
         i_fetch.send(tl, 1'b1, i);
         fin(1);
         chk(two_word_o, 1, "two word");
         chk(opcode_o, ld[23:16], "pair op");
         chk(cycles_o, 2, "pair cyc");
         chk(prog_addr_o, {tl[6:0], ld[15:0]}, "addr");
         chk(tail_nonzero_o, i == 3, "tail top");
      end
      one(24'h003579, 1'b0);
      chk(opcode_o, `IFCD_OP_NOP, "lone tail");
      chk(two_word_o, 0, "lone two");
      chk(cycles_o, 1, "lone cyc");
      chk(illegal_o, 0, "lone ill");
   endtask : t_pair
   task automatic t_skip();
      i_fetch.send(24'hF20000, 1'b1, 0);
      i_fetch.send(24'h5A1234, 1'b0, 0);
      fin(1);
      chk(opcode_o, 8'hF2, "skip op");
      chk(cycles_o, 2, "skip 1w");
      i_fetch.send(24'hF30000, 1'b1, 0);
      i_fetch.send({`IFCD_OP_GOTO2, 16'h1111}, 1'b0, 0);
      i_fetch.send(24'h000022, 1'b0, 0);
      fin(1);
      chk(cycles_o, 3, "skip 2w");
      i_fetch.send(24'hF40000, 1'b0, 0);
      fin(1);
      chk(cycles_o, 1, "no skip");
      one(24'h4C0F0F, 1'b0);
      chk(opcode_o, 8'h4C, "after");
   endtask : t_skip
   task automatic t_abort();
      i_fetch.send({`IFCD_OP_CALL2, 16'h2222}, 1'b0, 0);
      i_fetch.idle(1);
      do_reset(2);
      one(24'h4C0F0F, 1'b0);
      chk(two_word_o, 0, "abort two");
      chk(opcode_o, 8'h4C, "abort op");
   endtask : t_abort
   initial begin
      do_reset(10);
      t_word();
      t_file_bit();
      t_lit();
      t_mac();
      t_dsp();
      t_ctrl();
      t_pair();
      t_skip();
      t_abort();
      results();
   end
endmodule : tb_top
